// file: rtl/eeprom_host_pkg.sv
// Constants, timing counts and carrier types for the parallel EEPROM host.
// Assumes a 100 MHz core clock; all pin timings are derived from it here.
package eeprom_host_pkg;

   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int PAGE_LSB = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int CNT_W = 20;
   localparam int SYNC_W = 3;
   localparam int SYNC_LAT = 4;

   // Pin times in ns, window maximum in us, write cycle in ms
   localparam int T_RC_NS = 90;
   localparam int T_OHZ_NS = 40;
   localparam int T_OES_NS = 10;
   localparam int T_WP_NS = 100;
   localparam int T_WPH_NS = 100;
   localparam int T_AH_NS = 50;
   localparam int LOAD_WIN_MIN_NS = 200;
   localparam int LOAD_WIN_MAX_US = 100;
   localparam int T_WC_MS = 10;

   // Least times round up, longest times round down
   localparam int RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_CYC = RC_CYC + SYNC_LAT;
   localparam int OHZ_CYC = (T_OHZ_NS * CLK_MHZ + 999) / 1000;
   localparam int OES_CYC = (T_OES_NS * CLK_MHZ + 999) / 1000;
   localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
   localparam int AH_CYC = (T_AH_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC = (WPH_CYC > AH_CYC) ? WPH_CYC : AH_CYC;
   localparam int BLC_MIN_CYC = (LOAD_WIN_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int BLC_MAX_CYC = LOAD_WIN_MAX_US * CLK_MHZ;
   localparam int WC_CYC = T_WC_MS * 1000 * CLK_MHZ;
   localparam int CLOSE_MARGIN = 4;

   typedef logic [CNT_W-1:0] cnt_t;

   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_RD_STROBE = 10'h002,
      ST_RD_RECOVER = 10'h004,
      ST_WR_SETUP = 10'h008,
      ST_WR_PULSE = 10'h010,
      ST_WR_HOLD = 10'h020,
      ST_GAP = 10'h040,
      ST_WAIT_TIMER = 10'h080,
      ST_POLL_STROBE = 10'h100,
      ST_POLL_RECOVER = 10'h200
   } state_e;

   typedef struct packed {
      logic write;
      logic last;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } cmd_s;

endpackage : eeprom_host_pkg

// file: rtl/eeprom_page_host.sv
// Host controller driving a byte-wide parallel EEPROM: reads, page loads,
// and write-completion by toggle polling or by full write-cycle wait.
// Assumes the testbench resolves the data bus from dq_out and dq_oe.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Every byte of one page load keeps address bits 15 to 7 unchanged.
// - Between loads the output drive line may pulse low with select and strobe high.
// - Output drive low with select low and strobe high between loads is a polling read.
// - Each byte load follows the single write-strobe-controlled write timing.
// - Successive byte loads start between 0.2 and 100 microseconds apart.
// - Without polling the host waits the full 10 ms before the next access.
// - Polling accesses are ordinary reads obeying all read timing.
// - The toggling bit has no fixed first or last level; only two equal reads count.
// - Select and drive low reads, select and strobe low writes, select high idles.
module eeprom_page_host #(
   parameter int BLC_MAX_CYC = eeprom_host_pkg::BLC_MAX_CYC,
   parameter int WC_CYC = eeprom_host_pkg::WC_CYC,
   parameter bit POLL_EN = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire eeprom_host_pkg::cmd_s cmd,
   output logic cmd_ready,
   output logic [eeprom_host_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic wr_done,
   output logic busy,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [eeprom_host_pkg::ADDR_W-1:0] addr,
   output logic [eeprom_host_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [eeprom_host_pkg::DATA_W-1:0] dq_in
);

   ////////////////////////////////////////////////////////////////////////////
   localparam int PG_W = eeprom_host_pkg::ADDR_W - eeprom_host_pkg::PAGE_LSB;
   localparam int ACCEPT_LIM = BLC_MAX_CYC - 2 * eeprom_host_pkg::CLOSE_MARGIN;
   localparam int CLOSE_LIM = BLC_MAX_CYC - eeprom_host_pkg::CLOSE_MARGIN;

   eeprom_host_pkg::state_e state_reg, state_next;
   eeprom_host_pkg::cmd_s cur_reg, cur_next;
   eeprom_host_pkg::cnt_t cnt_reg, cnt_next;
   eeprom_host_pkg::cnt_t blc_reg, blc_next;
   eeprom_host_pkg::cnt_t wc_reg, wc_next;
   logic [PG_W-1:0] page_reg, page_next;
   logic pend_reg, pend_next;
   logic first_reg, first_next;
   logic poll_prev_reg, poll_prev_next;
   logic poll_have_reg, poll_have_next;
   logic poll_ok_reg, poll_ok_next;
   logic cmd_ready_reg, cmd_ready_next;
   logic [eeprom_host_pkg::DATA_W-1:0] rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic wr_done_reg, wr_done_next;
   logic busy_reg, busy_next;
   logic ce_n_reg, ce_n_next;
   logic oe_n_reg, oe_n_next;
   logic we_n_reg, we_n_next;
   logic [eeprom_host_pkg::ADDR_W-1:0] addr_reg, addr_next;
   logic [eeprom_host_pkg::DATA_W-1:0] dq_out_reg, dq_out_next;
   logic dq_oe_reg, dq_oe_next;
   logic [eeprom_host_pkg::DATA_W-1:0] dq_sync;

   ////////////////////////////////////////////////////////////////////////////
   pin_sync #(
      .WIDTH(eeprom_host_pkg::DATA_W)
   ) u_dq_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in(dq_in),
      .sync_out(dq_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic go;
      logic end_page;
      logic fin;
      eeprom_host_pkg::cmd_s sel;
      go = 1'b0;
      end_page = 1'b0;
      fin = 1'b0;
      sel = pend_reg ? cur_reg : cmd;
      state_next = state_reg;
      cur_next = cur_reg;
      cnt_next = cnt_reg + eeprom_host_pkg::cnt_t'(1);
      blc_next = (blc_reg == eeprom_host_pkg::cnt_t'(BLC_MAX_CYC)) ? blc_reg :
                 blc_reg + eeprom_host_pkg::cnt_t'(1);
      wc_next = (wc_reg == eeprom_host_pkg::cnt_t'(WC_CYC)) ? wc_reg :
                wc_reg + eeprom_host_pkg::cnt_t'(1);
      page_next = page_reg;
      pend_next = pend_reg;
      first_next = first_reg;
      poll_prev_next = poll_prev_reg;
      poll_have_next = poll_have_reg;
      poll_ok_next = poll_ok_reg;
      rd_data_next = rd_data_reg;
      rd_valid_next = 1'b0;
      wr_done_next = 1'b0;
      ce_n_next = ce_n_reg;
      oe_n_next = oe_n_reg;
      we_n_next = we_n_reg;
      addr_next = addr_reg;
      dq_out_next = dq_out_reg;
      dq_oe_next = dq_oe_reg;
      case (state_reg)
         eeprom_host_pkg::ST_IDLE:
         begin
            go = pend_reg || (cmd_valid && cmd_ready_reg);
            if (go)
            begin
               cur_next = sel;
               pend_next = 1'b0;
               cnt_next = '0;
               addr_next = sel.addr;
               ce_n_next = 1'b0;
               if (sel.write)
               begin
                  page_next = sel.addr[eeprom_host_pkg::ADDR_W-1:eeprom_host_pkg::PAGE_LSB];
                  first_next = 1'b1;
                  dq_out_next = sel.data;
                  dq_oe_next = 1'b1;
                  state_next = eeprom_host_pkg::ST_WR_SETUP;
               end
               else
               begin
                  oe_n_next = 1'b0;
                  state_next = eeprom_host_pkg::ST_RD_STROBE;
               end
            end
         end
         eeprom_host_pkg::ST_RD_STROBE, eeprom_host_pkg::ST_POLL_STROBE:
         begin
            // Strobe covers access time plus synchroniser latency
            if (cnt_reg == eeprom_host_pkg::cnt_t'(eeprom_host_pkg::RD_CYC - 1))
            begin
               ce_n_next = 1'b1;
               oe_n_next = 1'b1;
               cnt_next = '0;
               if (state_reg == eeprom_host_pkg::ST_RD_STROBE)
               begin
                  rd_data_next = dq_sync;
                  rd_valid_next = 1'b1;
                  state_next = eeprom_host_pkg::ST_RD_RECOVER;
               end
               else
               begin
                  // Only two equal samples count, never an absolute level
                  poll_ok_next = poll_have_reg &&
                                 (poll_prev_reg == dq_sync[eeprom_host_pkg::TOGGLE_BIT]);
                  poll_prev_next = dq_sync[eeprom_host_pkg::TOGGLE_BIT];
                  poll_have_next = 1'b1;
                  state_next = eeprom_host_pkg::ST_POLL_RECOVER;
               end
            end
         end
         eeprom_host_pkg::ST_RD_RECOVER:
         begin
            // Bus float time before anything drives again
            if (cnt_reg == eeprom_host_pkg::cnt_t'(eeprom_host_pkg::OHZ_CYC - 1))
            begin
               state_next = eeprom_host_pkg::ST_IDLE;
            end
         end
         eeprom_host_pkg::ST_WR_SETUP:
         begin
            if (cnt_reg >= eeprom_host_pkg::cnt_t'(eeprom_host_pkg::OES_CYC - 1) &&
                (first_reg ||
                 blc_reg >= eeprom_host_pkg::cnt_t'(eeprom_host_pkg::BLC_MIN_CYC - 1)))
            begin
               we_n_next = 1'b0;
               blc_next = '0;
               first_next = 1'b0;
               cnt_next = '0;
               state_next = eeprom_host_pkg::ST_WR_PULSE;
            end
         end
         eeprom_host_pkg::ST_WR_PULSE:
         begin
            if (cnt_reg == eeprom_host_pkg::cnt_t'(eeprom_host_pkg::WP_CYC - 1))
            begin
               we_n_next = 1'b1;
               cnt_next = '0;
               state_next = eeprom_host_pkg::ST_WR_HOLD;
            end
         end
         eeprom_host_pkg::ST_WR_HOLD:
         begin
            // Covers address hold and strobe-high recovery together
            if (cnt_reg == eeprom_host_pkg::cnt_t'(eeprom_host_pkg::HOLD_CYC - 1))
            begin
               ce_n_next = 1'b1;
               dq_oe_next = 1'b0;
               cnt_next = '0;
               if (cur_reg.last)
               begin
                  end_page = 1'b1;
               end
               else
               begin
                  state_next = eeprom_host_pkg::ST_GAP;
               end
            end
         end
         eeprom_host_pkg::ST_GAP:
         begin
            // Select stays high, so drive pulses elsewhere are harmless
            if (cmd_valid && cmd_ready_reg)
            begin
               cur_next = cmd;
               if (cmd.write &&
                   cmd.addr[eeprom_host_pkg::ADDR_W-1:eeprom_host_pkg::PAGE_LSB] == page_reg)
               begin
                  addr_next = cmd.addr;
                  dq_out_next = cmd.data;
                  dq_oe_next = 1'b1;
                  ce_n_next = 1'b0;
                  cnt_next = '0;
                  state_next = eeprom_host_pkg::ST_WR_SETUP;
               end
               else
               begin
                  // Other page or a read closes this page first
                  pend_next = 1'b1;
                  end_page = 1'b1;
               end
            end
            else if (blc_reg >= eeprom_host_pkg::cnt_t'(CLOSE_LIM))
            begin
               end_page = 1'b1;
            end
         end
         eeprom_host_pkg::ST_WAIT_TIMER:
         begin
            fin = (wc_reg >= eeprom_host_pkg::cnt_t'(WC_CYC - 1));
         end
         eeprom_host_pkg::ST_POLL_RECOVER:
         begin
            if (cnt_reg == eeprom_host_pkg::cnt_t'(eeprom_host_pkg::OHZ_CYC - 1))
            begin
               // Timeout backstop: device is done by then anyway
               if (poll_ok_reg || wc_reg >= eeprom_host_pkg::cnt_t'(WC_CYC - 1))
               begin
                  fin = 1'b1;
               end
               else
               begin
                  ce_n_next = 1'b0;
                  oe_n_next = 1'b0;
                  cnt_next = '0;
                  state_next = eeprom_host_pkg::ST_POLL_STROBE;
               end
            end
         end
         default:
         begin
            state_next = eeprom_host_pkg::ST_IDLE;
         end
      endcase
      if (end_page)
      begin
         wc_next = '0;
         cnt_next = '0;
         poll_have_next = 1'b0;
         poll_ok_next = 1'b0;
         addr_next = cur_reg.addr;
         if (POLL_EN)
         begin
            ce_n_next = 1'b0;
            oe_n_next = 1'b0;
            dq_oe_next = 1'b0;
            state_next = eeprom_host_pkg::ST_POLL_STROBE;
         end
         else
         begin
            state_next = eeprom_host_pkg::ST_WAIT_TIMER;
         end
      end
      if (fin)
      begin
         wr_done_next = 1'b1;
         state_next = eeprom_host_pkg::ST_IDLE;
      end
      cmd_ready_next = !pend_next &&
                       ((state_next == eeprom_host_pkg::ST_IDLE) ||
                        (state_next == eeprom_host_pkg::ST_GAP &&
                         blc_next < eeprom_host_pkg::cnt_t'(ACCEPT_LIM)));
      busy_next = (state_next != eeprom_host_pkg::ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= eeprom_host_pkg::ST_IDLE;
         cur_reg <= '0;
         cnt_reg <= '0;
         blc_reg <= '0;
         wc_reg <= '0;
         page_reg <= '0;
         pend_reg <= 1'b0;
         first_reg <= 1'b0;
         poll_prev_reg <= 1'b0;
         poll_have_reg <= 1'b0;
         poll_ok_reg <= 1'b0;
         cmd_ready_reg <= 1'b0;
         rd_data_reg <= '0;
         rd_valid_reg <= 1'b0;
         wr_done_reg <= 1'b0;
         busy_reg <= 1'b0;
         ce_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         addr_reg <= 16'h0000;
         dq_out_reg <= '0;
         dq_oe_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         cnt_reg <= cnt_next;
         blc_reg <= blc_next;
         wc_reg <= wc_next;
         page_reg <= page_next;
         pend_reg <= pend_next;
         first_reg <= first_next;
         poll_prev_reg <= poll_prev_next;
         poll_have_reg <= poll_have_next;
         poll_ok_reg <= poll_ok_next;
         cmd_ready_reg <= cmd_ready_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
         wr_done_reg <= wr_done_next;
         busy_reg <= busy_next;
         ce_n_reg <= ce_n_next;
         oe_n_reg <= oe_n_next;
         we_n_reg <= we_n_next;
         addr_reg <= addr_next;
         dq_out_reg <= dq_out_next;
         dq_oe_reg <= dq_oe_next;
      end
   end

   assign cmd_ready = cmd_ready_reg;
   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign wr_done = wr_done_reg;
   assign busy = busy_reg;
   assign ce_n = ce_n_reg;
   assign oe_n = oe_n_reg;
   assign we_n = we_n_reg;
   assign addr = addr_reg;
   assign dq_out = dq_out_reg;
   assign dq_oe = dq_oe_reg;

endmodule : eeprom_page_host
`default_nettype wire

// file: rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs arrive asynchronously from device pins.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);

   ////////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic out_reg;
         logic out_next;
         // Stage one feeds stage two only
         always_comb
         begin
            out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
         end
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               out_reg <= 1'b0;
            end
            else
            begin
               s1_reg <= pin_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               out_reg <= out_next;
            end
         end
         assign sync_out[i] = out_reg;
      end
   endgenerate

endmodule : pin_sync
`default_nettype wire

// file: tb/eeprom_device_model.sv
// Behavioural byte-wide EEPROM: page buffer, self-timed write, toggle bit.
// Assumes the bench resolves the data bus and feeds it back as bus.
`timescale 1ns/10ps
`default_nettype none
module eeprom_device_model #(
   parameter realtime WT_NS = 3000.0
) (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [15:0] addr,
   input wire logic [7:0] bus,
   output logic [7:0] dq_dev
);
   logic [7:0] mem [logic [15:0]];
   logic [15:0] pa [$];
   logic [7:0] pd [$];
   logic [7:0] rd_val = 8'h00;
   logic [7:0] held = 8'h00;
   logic tog = 1'b0;
   realtime t_last = 0.0;
   wire logic drive = !ce_n && !oe_n && we_n;
   always @(posedge we_n)
   begin
      if (!ce_n && oe_n)
      begin
         // Start level follows address and data, so it is not fixed
         if (pa.size() == 0)
            tog = addr[0] ^ bus[0];
         pa.push_back(addr);
         pd.push_back(bus);
         t_last = $realtime;
      end
   end
   always @(negedge oe_n)
   begin
      // Select may fall in the same step; let it settle first
      #1;
      if (!ce_n && we_n)
      begin
         if (pa.size() != 0 && $realtime >= t_last + WT_NS)
         begin
            while (pa.size() != 0)
               mem[pa.pop_front()] = pd.pop_front();
         end
         if (pa.size() != 0)
         begin
            tog = ~tog;
            rd_val = {~pd[$][7], tog, pd[$][5:0]};
         end
         else
            rd_val = mem.exists(addr) ? mem[addr] : addr[7:0] ^ addr[15:8] ^ 8'h5a;
      end
   end
   // Released bus shows the inverse, never a stale copy
   always @(rd_val or drive)
   begin
      if (drive)
         held = rd_val;
   end
   assign dq_dev = drive ? rd_val : ~held;
endmodule : eeprom_device_model
`default_nettype wire

// file: tb/eeprom_page_checker.sv
// Pin-timing assertions for the EEPROM page host.
// Assumes binding to every eeprom_page_host; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module eeprom_page_checker #(
   parameter int BLC_MAX_CYC = 200,
   parameter int WC_CYC = 500
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic busy,
   input wire logic rd_valid,
   input wire logic wr_done,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic dq_oe,
   input wire logic [eeprom_host_pkg::ADDR_W-1:0] addr
);
   ////////////////////////////////////////////////////////////////////////////////
   // Cycles since the last strobe fall, open page and its upper address
   logic [15:0] gap_reg, gap_next;
   logic open_reg, open_next, we_d_reg, oe_d_reg;
   logic [8:0] page_reg, page_next;
   always_comb
   begin
      gap_next = (gap_reg == 16'hffff) ? gap_reg : gap_reg + 16'h0001;
      open_next = open_reg;
      page_next = page_reg;
      if (we_d_reg && !we_n)
      begin
         gap_next = 16'h0001;
         open_next = 1'b1;
         page_next = addr[15:7];
      end
      // A read strobe or a finished write means the page has been closed
      if ((oe_d_reg && !oe_n) || wr_done)
         open_next = 1'b0;
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap_reg <= 16'h0000;
         open_reg <= 1'b0;
         page_reg <= 9'h000;
         we_d_reg <= 1'b1;
         oe_d_reg <= 1'b1;
      end
      else
      begin
         gap_reg <= gap_next;
         open_reg <= open_next;
         page_reg <= page_next;
         we_d_reg <= we_n;
         oe_d_reg <= oe_n;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_we_low;
      !we_n[*8] ##1 !we_n[*2];
   endsequence
   sequence s_rd_low;
      (!oe_n && !ce_n && we_n && !dq_oe)[*8] ##1 (!oe_n && !ce_n)[*5];
   endsequence
   a_no_mode_clash: assert property (!(!oe_n && !we_n))
      else $error("read and write strobes low together");
   a_write_selected: assert property (!we_n |-> !ce_n && dq_oe)
      else $error("write strobe without select or data");
   a_we_pulse_width: assert property ($fell(we_n) |-> s_we_low ##1 we_n)
      else $error("write strobe width wrong");
   a_load_spacing: assert property ($fell(we_n) && open_reg |-> gap_reg >= 16'h0014)
      else $error("byte loads too close");
   a_page_addr_hold: assert property ($fell(we_n) && open_reg |-> addr[15:7] == page_reg)
      else $error("page address changed in a page");
   a_window_bound: assert property (open_reg |-> gap_reg <= BLC_MAX_CYC)
      else $error("byte load window overrun");
   a_read_timing: assert property ($fell(oe_n) |-> s_rd_low ##1 oe_n)
      else $error("read strobe timing wrong");
   a_read_recovery: assert property ($rose(oe_n) |-> oe_n[*4])
      else $error("read recovery too short");
   a_read_result: assert property (rd_valid |-> oe_n && $past(oe_n) == 1'b0)
      else $error("read data not at strobe end");
   a_standby_idle: assert property (!busy |-> ce_n && oe_n && we_n && !dq_oe)
      else $error("pins not idle while not busy");
endmodule : eeprom_page_checker
bind eeprom_page_host eeprom_page_checker #(.BLC_MAX_CYC(BLC_MAX_CYC), .WC_CYC(WC_CYC)) chk_u (
   .core_clk(core_clk), .rst_n(rst_n), .busy(busy), .rd_valid(rd_valid),
   .wr_done(wr_done), .ce_n(ce_n),
   .oe_n(oe_n), .we_n(we_n), .dq_oe(dq_oe), .addr(addr));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench: page host against a behavioural EEPROM model.
// Assumes shortened window and write-cycle counts to keep the run short.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, want) begin checks_done++; if ((got) !== (want)) begin fail_count++; \
   $display("wrong value at %0t: %h expected %h", $time, got, want); end end
module testbench;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   eeprom_host_pkg::cmd_s cmd = '0;
   logic cmd_ready, rd_valid, wr_done, busy, ce_n, oe_n, we_n, dq_oe;
   logic [7:0] rd_data, dq_out, dq_dev, bus;
   logic [15:0] addr;
   logic t_valid = 1'b0;
   logic t_ready, t_done;
   logic [7:0] exp_b;
   localparam int T_WC = 500;
   logic [31:0] seed = 32'h0000_c1ad;
   int fail_count = 0;
   int checks_done = 0;
   int dones = 0;
   logic [7:0] ref_mem [logic [15:0]];
   logic [7:0] exp_q [$];
   assign bus = dq_oe ? dq_out : dq_dev;
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   eeprom_page_host #(.BLC_MAX_CYC(200), .WC_CYC(500), .POLL_EN(1'b1)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid), .wr_done(wr_done),
      .busy(busy), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(bus));
   eeprom_device_model dev_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
      .bus(bus), .dq_dev(dq_dev));
   // Second host without polling, so the timed wait is exercised
   eeprom_page_host #(.BLC_MAX_CYC(1000), .WC_CYC(T_WC), .POLL_EN(1'b0)) dut_t (
      .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(t_valid), .cmd(cmd),
      .cmd_ready(t_ready), .rd_data(), .rd_valid(), .wr_done(t_done), .busy(), .ce_n(),
      .oe_n(), .we_n(), .addr(), .dq_out(), .dq_oe(), .dq_in(bus));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic send(input logic w, input logic l, input logic [15:0] a, input logic [7:0] d);
      int n = 0;
      cmd_valid <= 1'b1;
      cmd <= '{w, l, a, d};
      if (w)
         ref_mem[a] = d;
      else
         exp_q.push_back(ref_mem.exists(a) ? ref_mem[a] : a[7:0] ^ a[15:8] ^ 8'h5a);
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (cmd_ready !== 1'b1 && n < 5000);
      `CHK(cmd_ready, 1'b1)
   endtask : send
   task automatic settle(input int n0);
      int n = 0;
      while (dones == n0 && n < 3000)
      begin
         @(posedge core_clk);
         n++;
      end
      `CHK(dones, n0 + 1)
   endtask : settle
   // Mode 0 last byte, 1 window expiry, 2 foreign read, 3 foreign page write
   task automatic page_run(input int n, input int mode);
      logic [31:0] r;
      logic [15:0] a;
      int d0;
      int k = 0;
      r = rnd();
      a = {r[15:7], 7'(128 - n)};
      d0 = dones;
      for (int i = 0; i < n; i++)
         send(1'b1, 1'(mode == 0 && i == n - 1), a + 16'(i), 8'(rnd()));
      if (mode == 2)
         send(1'b0, 1'b0, a ^ 16'h8000, 8'h00);
      if (mode == 3)
         send(1'b1, 1'b1, a ^ 16'h0080, 8'(rnd()));
      cmd_valid <= 1'b0;
      settle(d0);
      if (mode == 3)
         settle(d0 + 1);
      for (int i = 0; i < n; i++)
         send(1'b0, 1'b0, a + 16'(i), 8'h00);
      if (mode == 3)
         send(1'b0, 1'b0, a ^ 16'h0080, 8'h00);
      cmd_valid <= 1'b0;
      while (exp_q.size() != 0 && k < 5000)
      begin
         @(posedge core_clk);
         k++;
      end
      `CHK(exp_q.size(), 0)
   endtask : page_run
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk)
   begin
      if (rd_valid === 1'b1)
      begin
         exp_b = exp_q.pop_front();
         `CHK(rd_data, exp_b)
      end
      if (wr_done === 1'b1)
         dones++;
   end
   initial
   begin
      int np [5] = '{128, 2, 3, 2, 1};
      int md [5] = '{0, 1, 2, 3, 0};
      int n = 0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 5; i++)
         page_run(np[i], md[i]);
      // One timed page on the host without polling
      cmd <= '{1'b1, 1'b1, 16'(rnd()), 8'(rnd())};
      t_valid <= 1'b1;
      do
      begin
         @(posedge core_clk);
      end
      while (t_ready !== 1'b1);
      t_valid <= 1'b0;
      while (t_done !== 1'b1 && n < 3000)
      begin
         @(posedge core_clk);
         n++;
      end
      `CHK(n, 2 + eeprom_host_pkg::WP_CYC + eeprom_host_pkg::HOLD_CYC + T_WC)
      // Reset during a byte load must free the pins at once
      send(1'b1, 1'b0, 16'(rnd()), 8'h00);
      cmd_valid <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b0;
      #1;
      `CHK({ce_n, oe_n, we_n, dq_oe}, 4'hE)
      stop_test();
   end
   initial
   begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      stop_test();
   end
endmodule : testbench
`default_nettype wire
